// *** hw/isc_consts.svh ***
// offsets, field positions, reset values and timing figures of the interrupt and standby control
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
// register byte offsets
`define ISC_OFS_REQUEST 8'h00
`define ISC_OFS_MASK 8'h04
`define ISC_OFS_PRIO 8'h08
`define ISC_OFS_KEYRET 8'h0C
`define ISC_OFS_EDGESEL 8'h10
`define ISC_OFS_SAMPSEL 8'h14
`define ISC_OFS_WDTMODE 8'h18
`define ISC_OFS_SETTLE 8'h1C
`define ISC_OFS_STATUS 8'h20
`define ISC_OFS_STANDBY 8'h24
// source bit positions in the request, mask and priority registers
`define ISC_SRC_WDT 0
`define ISC_SRC_EXT0 1
`define ISC_SRC_EXT3 4
`define ISC_SRC_SERIAL 5
`define ISC_SRC_WATCHINT 6
`define ISC_SRC_TIMER1 7
`define ISC_SRC_TIMER2 8
`define ISC_SRC_WATCHTEST 9
`define ISC_NUM_VECTORED 9
// implemented bits of the flag registers
`define ISC_REQ_BITS 16'h03FF
`define ISC_PRIO_BITS 16'h01FF
// key return and status word fields
`define ISC_KEY_REQ_BIT 0
`define ISC_KEY_MASK_BIT 1
`define ISC_PSW_IE_BIT 0
`define ISC_PSW_ISP_BIT 1
// reset values
`define ISC_MASK_RST 16'h03FF
`define ISC_PRIO_RST 16'h01FF
`define ISC_KEY_RST 8'h02
`define ISC_WDTMODE_RST 2'h2
// watchdog overflow modes
`define ISC_WDT_RESTART 2'h0
`define ISC_WDT_NMI 2'h1
`define ISC_WDT_MASKABLE 2'h2
// vectors
`define ISC_VEC_RESTART 16'h0000
`define ISC_VEC_WDT 16'h0004
`define ISC_VEC_EXT0 16'h0006
`define ISC_VEC_EXT1 16'h0008
`define ISC_VEC_EXT2 16'h000A
`define ISC_VEC_EXT3 16'h000C
`define ISC_VEC_SERIAL 16'h000E
`define ISC_VEC_WATCHINT 16'h0012
`define ISC_VEC_TIMER1 16'h0016
`define ISC_VEC_TIMER2 16'h0018
`define ISC_VEC_BREAK 16'h003E
// timing: clock rate and oscillator settle times in ms
`define ISC_CLK_MHZ 100
`define ISC_SETTLE0_MS 0.98
`define ISC_SETTLE1_MS 1.95
`define ISC_SETTLE2_MS 3.91
`define ISC_SETTLE3_MS 7.81
`define ISC_SETTLE4_MS 31.3
`define ISC_SETTLE_W 22
`define ISC_STACK_DEPTH 8
`endif

// *** hw/isc_pkg.sv ***
// types shared by the interrupt and standby control
package isc_pkg;
   typedef enum logic [1:0] {ISC_RUN, ISC_HALT, ISC_STOP, ISC_SETTLE} isc_mode_t;
   typedef enum logic [1:0] {ISC_OFF_NONE, ISC_OFF_NMI, ISC_OFF_BRK, ISC_OFF_MASK} isc_offer_t;
   typedef enum logic [2:0] {ISC_I_OTHER, ISC_I_EI, ISC_I_DI, ISC_I_BRK, ISC_I_IRQ_RETURN_INSTR,
      ISC_I_BREAK_RETURN_INSTR, ISC_I_HALT, ISC_I_STOP} isc_instr_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } isc_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } isc_apb_rsp_t;
   typedef struct packed {
      logic instrValid;
      isc_instr_t instrCode;
      logic irqAck;
   } isc_cpu_req_t;
   typedef struct packed {
      logic irqReq;
      logic [15:0] irqVector;
      logic irqNmi;
      logic irqBrk;
      logic cpuClkRun;
      logic mainOscRun;
      logic restartReq;
   } isc_cpu_rsp_t;
   typedef struct packed {
      logic watchdogOverflowIrq;
      logic serialTransferEndIrq;
      logic watchIntervalIrq;
      logic timerOneMatchIrq;
      logic timerTwoMatchIrq;
      logic watchOverflowTestFlag;
   } isc_src_t;
endpackage : isc_pkg

// *** hw/isc_top.sv ***
// interrupt arbitration, vectoring and halt/stop standby control with an APB register file
// Operation
// R01 - eleven maskable sources, nine vectored, two testable; the code has ten, nine vectored, one testable
// R02 - edge zero never wakes STOP, HALT if sampling
// R03 - watchdog overflow: restart, nonmaskable or maskable
// R04 - fixed vector per maskable source by priority
// R05 - reset restarts at zero; break vectors high
// R06 - test inputs only raise flags, never vector
// R07 - request, mask, priority flag registers, sixteen bits
// R08 - key return register holds request and mask
// R09 - edge zero to two selectable; three falling
// R10 - edge zero passes a sampled noise filter
// R11 - global enable blocks maskables; cleared on accept
// R12 - in-service level bit tracks serviced priority
// R13 - nonmaskable watchdog beats every other request
// R14 - pending requests wait for enable or return
// R15 - default order breaks ties within one level
// R16 - break ignores level and enable, keeps level
// R17 - acknowledge saves state, clears enable; maskable sets level
// R18 - return instructions restore saved status word
// R19 - halt stops the CPU clock, oscillators run
// R20 - halt released by unmasked, nonmaskable or test
// R21 - stop halts oscillator; limited set wakes it
// R22 - stop release waits selected oscillator settle time
// R23 - acknowledge clears the serviced request flag
`timescale 1ns/10ps
`include "isc_consts.svh"
module isc_top import isc_pkg::*; #(
   parameter int SETTLE_CYC0 = int'($ceil(`ISC_SETTLE0_MS * 1000.0 * `ISC_CLK_MHZ)),
   parameter int SETTLE_CYC1 = int'($ceil(`ISC_SETTLE1_MS * 1000.0 * `ISC_CLK_MHZ)),
   parameter int SETTLE_CYC2 = int'($ceil(`ISC_SETTLE2_MS * 1000.0 * `ISC_CLK_MHZ)),
   parameter int SETTLE_CYC3 = int'($ceil(`ISC_SETTLE3_MS * 1000.0 * `ISC_CLK_MHZ)),
   parameter int SETTLE_CYC4 = int'($ceil(`ISC_SETTLE4_MS * 1000.0 * `ISC_CLK_MHZ))
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire isc_apb_req_t apbReq,
   output isc_apb_rsp_t apbRsp,
   input wire isc_cpu_req_t cpuReq,
   output isc_cpu_rsp_t cpuRsp,
   input wire isc_src_t irqSrc,
   input wire logic [4:0] stopCapable,
   input wire logic [3:0] extEdgePin,
   input wire logic [7:0] portFourPin
);
   // counters must fit the settle counter
   if (SETTLE_CYC0 < 1 || SETTLE_CYC1 < 1 || SETTLE_CYC2 < 1 || SETTLE_CYC3 < 1
      || SETTLE_CYC4 < 1 || SETTLE_CYC4 >= (1 << `ISC_SETTLE_W)) begin : g_bad_settle
      $error("isc_top: settle counts out of range");
   end

   // whole state of the block
   typedef struct packed {
      logic [11:0] pinMeta;          // first synchroniser stage, ext pins then port 4
      logic [11:0] pinSync;          // second stage
      logic [11:0] pinPrev;          // previous synchronised level for edges
      logic [5:0] sampCnt;           // noise eliminator sampling divider
      logic p0Samp;                  // last sample of edge zero pin
      logic p0Filt;                  // filtered level of edge zero pin
      logic [15:0] reqFlags;         // request_flag_register
      logic [15:0] maskFlags;        // mask_flag_register
      logic [15:0] prioFlags;        // priority_flag_register, 0 = high level
      logic [7:0] keyReg;            // key_return_register
      logic [7:0] edgeSel;           // edge_select_register
      logic [7:0] sampSel;           // sampling_clock_select
      logic [1:0] wdtMode;           // watchdog overflow handling
      logic [2:0] settleSel;         // osc_settle_select
      logic ie;                      // global_irq_enable
      logic ispHigh;                 // in_service_level_bit, 1 = serving high level
      logic holdOff;                 // one instruction must pass after a return
      logic brkPend;                 // software break waiting for acknowledge
      logic [3:0] sp;                // saved status word depth
      logic [2*`ISC_STACK_DEPTH-1:0] stk; // saved {ie, ispHigh} pairs
      isc_mode_t mode;               // run or standby state
      logic [`ISC_SETTLE_W-1:0] settleCnt; // oscillator settle countdown
      isc_offer_t offer;             // kind of request now offered to the core
      logic [3:0] offerIdx;          // offered maskable source
      logic offerHigh;               // offered source is high level
      isc_apb_rsp_t apb;             // registered bus answer
      isc_cpu_rsp_t cpu;             // registered core outputs
   } isc_state_t;

   // reset value of the whole state
   function automatic isc_state_t rstValue();
      isc_state_t s;
      s = '0;
      s.maskFlags = `ISC_MASK_RST;
      s.prioFlags = `ISC_PRIO_RST;
      s.keyReg = `ISC_KEY_RST;
      s.wdtMode = `ISC_WDTMODE_RST;
      s.mode = ISC_RUN;
      s.offer = ISC_OFF_NONE;
      s.cpu.irqVector = `ISC_VEC_RESTART;   // see R05
      s.cpu.cpuClkRun = 1'b1;
      s.cpu.mainOscRun = 1'b1;
      return s;
   endfunction : rstValue

   localparam isc_state_t RST_STATE = rstValue();

   // vector of each maskable source in default priority order
   function automatic logic [15:0] vecOf(input logic [3:0] idx);
      case (idx)
         4'h0: vecOf = `ISC_VEC_WDT;        // see R03
         4'h1: vecOf = `ISC_VEC_EXT0;       // see R04
         4'h2: vecOf = `ISC_VEC_EXT1;
         4'h3: vecOf = `ISC_VEC_EXT2;
         4'h4: vecOf = `ISC_VEC_EXT3;
         4'h5: vecOf = `ISC_VEC_SERIAL;
         4'h6: vecOf = `ISC_VEC_WATCHINT;
         4'h7: vecOf = `ISC_VEC_TIMER1;
         default: vecOf = `ISC_VEC_TIMER2;
      endcase
   endfunction : vecOf

   // valid-edge decode: 0 falling, 1 rising, 3 both, 2 none
   function automatic logic edgeHit(input logic [1:0] sel, input logic r, input logic f);
      edgeHit = (sel[0] & r) | (~sel[0] & ~sel[1] & f) | (sel[1] & sel[0] & f);
   endfunction : edgeHit

   // settle cycles for a selection; values above four take the longest
   function automatic logic [`ISC_SETTLE_W-1:0] settleOf(input logic [2:0] sel);
      case (sel)
         3'h0: settleOf = `ISC_SETTLE_W'(SETTLE_CYC0 - 1);
         3'h1: settleOf = `ISC_SETTLE_W'(SETTLE_CYC1 - 1);
         3'h2: settleOf = `ISC_SETTLE_W'(SETTLE_CYC2 - 1);
         3'h3: settleOf = `ISC_SETTLE_W'(SETTLE_CYC3 - 1);
         default: settleOf = `ISC_SETTLE_W'(SETTLE_CYC4 - 1);
      endcase
   endfunction : settleOf

   logic [1:0] rstSync;           // reset release synchroniser
   logic rstInt_n;                // synchronised reset
   isc_state_t st;                // registered state
   isc_state_t nx;                // next state
   logic [11:0] rise;             // synchronised rising edges
   logic [11:0] fall;             // synchronised falling edges
   logic [5:0] divMask;           // sampling period mask
   logic sampTick;                // noise filter sample strobe
   logic filtChange;              // filtered edge-zero level flips
   logic [15:0] evt;              // request set events this cycle
   logic keyEvt;                  // port 4 falling edge
   logic access;                  // APB access phase
   logic doWrite;                 // write takes effect this edge
   logic ackNow;                  // core takes the offered request
   logic [15:0] reqBase;          // request flags before set events
   logic [15:0] wakeSrc;          // unmasked requests able to wake
   logic wake;                    // standby release condition
   logic [8:0] pend;              // pending vectored maskable requests
   logic [8:0] cand;              // candidates of the winning level
   logic [3:0] selIdx;            // chosen maskable source
   logic selHigh;                 // chosen source is high level
   logic selOk;                   // chosen source may be accepted now

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstInt_n = rstSync[1];

   // outputs come straight from the state flops
   assign apbRsp = st.apb;
   assign cpuRsp = st.cpu;

   // next-state logic of the whole block
   always_comb begin
      nx = st;
      nx.cpu.restartReq = 1'b0;
      // pins pass two flops before anything looks at them
      nx.pinMeta = {portFourPin, extEdgePin};
      nx.pinSync = st.pinMeta;
      nx.pinPrev = st.pinSync;
      rise = st.pinSync & ~st.pinPrev;
      fall = ~st.pinSync & st.pinPrev;

      // noise eliminator: sel 0 samples on cpu clock, which stops in standby
      divMask = 6'h00;
      case (st.sampSel[1:0])
         2'h1: divMask = 6'h03;
         2'h2: divMask = 6'h0F;
         2'h3: divMask = 6'h3F;
         default: divMask = 6'h00;
      endcase
      if (st.sampSel[1:0] == 2'h0) begin
         sampTick = (st.mode == ISC_RUN);                    // see R02
      end else begin
         sampTick = (st.mode != ISC_STOP) && ((st.sampCnt & divMask) == 6'h00);
      end
      if (st.mode != ISC_STOP) begin
         nx.sampCnt = st.sampCnt + 6'h01;
      end
      // two equal samples in a row move the filtered level
      filtChange = sampTick && (st.pinSync[0] == st.p0Samp) && (st.p0Samp != st.p0Filt);
      if (sampTick) begin
         nx.p0Samp = st.pinSync[0];                          // see R10
      end
      if (filtChange) begin
         nx.p0Filt = st.p0Samp;
      end

      // request events
      evt = 16'h0000;
      evt[`ISC_SRC_WDT] = irqSrc.watchdogOverflowIrq && (st.wdtMode != `ISC_WDT_RESTART);
      evt[`ISC_SRC_EXT0] = filtChange &&
         edgeHit(st.edgeSel[1:0], st.p0Samp, ~st.p0Samp);    // see R09
      evt[`ISC_SRC_EXT0 + 1] = edgeHit(st.edgeSel[3:2], rise[1], fall[1]);
      evt[`ISC_SRC_EXT0 + 2] = edgeHit(st.edgeSel[5:4], rise[2], fall[2]);
      evt[`ISC_SRC_EXT3] = fall[3];                          // see R09
      evt[`ISC_SRC_SERIAL] = irqSrc.serialTransferEndIrq;
      evt[`ISC_SRC_WATCHINT] = irqSrc.watchIntervalIrq;
      evt[`ISC_SRC_TIMER1] = irqSrc.timerOneMatchIrq;
      evt[`ISC_SRC_TIMER2] = irqSrc.timerTwoMatchIrq;
      evt[`ISC_SRC_WATCHTEST] = irqSrc.watchOverflowTestFlag; // see R06
      // in stop the five peripheral interrupt sources raise requests and wake it only with their stopCapable bit set
      if (st.mode == ISC_STOP) begin
         evt[`ISC_SRC_WDT] = evt[`ISC_SRC_WDT] & stopCapable[0];        // see R21
         evt[`ISC_SRC_SERIAL] = evt[`ISC_SRC_SERIAL] & stopCapable[1];
         evt[`ISC_SRC_WATCHINT] = evt[`ISC_SRC_WATCHINT] & stopCapable[2];
         evt[`ISC_SRC_TIMER1] = evt[`ISC_SRC_TIMER1] & stopCapable[3];
         evt[`ISC_SRC_TIMER2] = evt[`ISC_SRC_TIMER2] & stopCapable[4];
      end
      keyEvt = |fall[11:4];                                  // see R08

      // APB: one wait state, write lands on the edge that sees pready
      access = apbReq.psel && apbReq.penable;
      doWrite = access && st.apb.pready && apbReq.pwrite && !st.apb.pslverr;
      nx.apb.pready = access && !st.apb.pready;
      nx.apb.pslverr = 1'b0;
      if (access && !st.apb.pready) begin
         nx.apb.prdata = 32'h00000000;
         case (apbReq.paddr)
            `ISC_OFS_REQUEST: nx.apb.prdata[15:0] = st.reqFlags;       // see R07
            `ISC_OFS_MASK: nx.apb.prdata[15:0] = st.maskFlags;
            `ISC_OFS_PRIO: nx.apb.prdata[15:0] = st.prioFlags;
            `ISC_OFS_KEYRET: nx.apb.prdata[7:0] = st.keyReg;
            `ISC_OFS_EDGESEL: nx.apb.prdata[7:0] = st.edgeSel;
            `ISC_OFS_SAMPSEL: nx.apb.prdata[7:0] = st.sampSel;
            `ISC_OFS_WDTMODE: nx.apb.prdata[1:0] = st.wdtMode;
            `ISC_OFS_SETTLE: nx.apb.prdata[2:0] = st.settleSel;
            `ISC_OFS_STATUS: nx.apb.prdata[1:0] = {st.ispHigh, st.ie};
            `ISC_OFS_STANDBY: nx.apb.prdata[1:0] = st.mode;
            default: nx.apb.pslverr = 1'b1;                  // unmapped address
         endcase
      end
      reqBase = st.reqFlags;
      if (doWrite) begin
         case (apbReq.paddr)
            `ISC_OFS_REQUEST: reqBase = apbReq.pwdata[15:0] & `ISC_REQ_BITS;
            `ISC_OFS_MASK: nx.maskFlags = apbReq.pwdata[15:0] & `ISC_REQ_BITS;
            `ISC_OFS_PRIO: nx.prioFlags = apbReq.pwdata[15:0] & `ISC_PRIO_BITS;
            `ISC_OFS_KEYRET: nx.keyReg = apbReq.pwdata[7:0] & 8'h03;
            `ISC_OFS_EDGESEL: nx.edgeSel = apbReq.pwdata[7:0] & 8'h3F;
            `ISC_OFS_SAMPSEL: nx.sampSel = apbReq.pwdata[7:0] & 8'h03;
            `ISC_OFS_WDTMODE: nx.wdtMode = apbReq.pwdata[1:0];         // see R03
            `ISC_OFS_SETTLE: nx.settleSel = apbReq.pwdata[2:0];        // see R22
            `ISC_OFS_STATUS: begin
               nx.ie = apbReq.pwdata[`ISC_PSW_IE_BIT];                 // see R11
               nx.ispHigh = apbReq.pwdata[`ISC_PSW_ISP_BIT];
            end
            default: begin
               nx.ie = nx.ie;                                // read-only or unmapped
            end
         endcase
      end

      // core instructions steer enable, break, return and standby
      if (cpuReq.instrValid) begin
         nx.holdOff = 1'b0;                                  // see R14
         case (cpuReq.instrCode)
            ISC_I_EI: nx.ie = 1'b1;                          // see R11
            ISC_I_DI: nx.ie = 1'b0;
            ISC_I_BRK: nx.brkPend = 1'b1;
            ISC_I_IRQ_RETURN_INSTR, ISC_I_BREAK_RETURN_INSTR: begin
               // restore the status word saved at acceptance
               if (st.sp != 4'h0) begin
                  nx.sp = st.sp - 4'h1;                      // see R18
                  nx.ie = st.stk[2*(st.sp-4'h1)+1];
                  nx.ispHigh = st.stk[2*(st.sp-4'h1)];
               end
               nx.holdOff = 1'b1;                            // see R14
            end
            ISC_I_HALT: begin
               if (st.mode == ISC_RUN) nx.mode = ISC_HALT;   // see R19
            end
            ISC_I_STOP: begin
               if (st.mode == ISC_RUN) nx.mode = ISC_STOP;   // see R21
            end
            default: nx.holdOff = 1'b0;
         endcase
      end

      // acknowledge of the registered offer
      ackNow = cpuReq.irqAck && st.cpu.irqReq;
      if (ackNow) begin
         // saturate rather than wrap: pushes past the top are dropped
         if (st.sp != 4'(`ISC_STACK_DEPTH)) begin
            nx.stk[2*st.sp +: 2] = {nx.ie, nx.ispHigh};      // see R17
            nx.sp = st.sp + 4'h1;
         end
         nx.ie = 1'b0;                                       // see R11
         case (st.offer)
            ISC_OFF_NMI: reqBase[`ISC_SRC_WDT] = 1'b0;       // see R23
            ISC_OFF_BRK: nx.brkPend = 1'b0;                  // see R16
            ISC_OFF_MASK: begin
               reqBase[st.offerIdx] = 1'b0;                  // see R23
               nx.ispHigh = st.offerHigh;                    // see R12
            end
            default: nx.brkPend = nx.brkPend;
         endcase
      end
      // a set arriving with a clear wins
      nx.reqFlags = reqBase | evt;
      if (keyEvt) begin
         nx.keyReg[`ISC_KEY_REQ_BIT] = 1'b1;                 // see R08
      end

      // standby release sources
      wakeSrc = st.reqFlags & ~st.maskFlags & `ISC_REQ_BITS;                  // see R20
      if (st.wdtMode == `ISC_WDT_NMI) begin
         wakeSrc[`ISC_SRC_WDT] = st.reqFlags[`ISC_SRC_WDT];
      end
      if (st.mode == ISC_STOP || st.sampSel[1:0] == 2'h0) begin
         wakeSrc[`ISC_SRC_EXT0] = 1'b0;                      // see R02
      end
      wake = (|wakeSrc) || (st.keyReg[`ISC_KEY_REQ_BIT] && !st.keyReg[`ISC_KEY_MASK_BIT]);

      // standby sequencing
      case (st.mode)
         ISC_HALT: begin
            if (wake) nx.mode = ISC_RUN;                     // see R20
         end
         ISC_STOP: begin
            if (wake) begin
               nx.mode = ISC_SETTLE;                         // see R21
               nx.settleCnt = settleOf(st.settleSel);
            end
         end
         ISC_SETTLE: begin
            if (st.settleCnt == '0) begin
               nx.mode = ISC_RUN;                            // see R22
            end else begin
               nx.settleCnt = st.settleCnt - 1'b1;
            end
         end
         default: nx.settleCnt = '0;
      endcase
      nx.cpu.cpuClkRun = (nx.mode == ISC_RUN);               // see R19
      nx.cpu.mainOscRun = (nx.mode != ISC_STOP);             // see R21

      // arbitration: high level first, then fixed order inside a level
      pend = st.reqFlags[8:0] & ~st.maskFlags[8:0];
      if (st.wdtMode != `ISC_WDT_MASKABLE) begin
         pend[`ISC_SRC_WDT] = 1'b0;
      end
      cand = ((pend & ~st.prioFlags[8:0]) != 9'h000) ? (pend & ~st.prioFlags[8:0]) : pend;
      selIdx = 4'h0;
      for (int i = `ISC_NUM_VECTORED - 1; i >= 0; i--) begin
         if (cand[i]) selIdx = 4'(i);                        // see R15
      end
      selHigh = !st.prioFlags[selIdx];
      selOk = st.ie && !st.holdOff && (selHigh || !st.ispHigh);   // see R14
      nx.offer = ISC_OFF_NONE;
      nx.offerIdx = selIdx;
      nx.offerHigh = selHigh;
      if (st.mode == ISC_RUN && !ackNow) begin
         if (st.wdtMode == `ISC_WDT_NMI && st.reqFlags[`ISC_SRC_WDT]) begin
            nx.offer = ISC_OFF_NMI;                          // see R13
         end else if (st.brkPend) begin
            nx.offer = ISC_OFF_BRK;                          // see R16
         end else if ((pend != 9'h000) && selOk) begin
            nx.offer = ISC_OFF_MASK;                         // see R01
         end
      end
      nx.cpu.irqReq = (nx.offer != ISC_OFF_NONE);
      nx.cpu.irqNmi = (nx.offer == ISC_OFF_NMI);
      nx.cpu.irqBrk = (nx.offer == ISC_OFF_BRK);
      case (nx.offer)
         ISC_OFF_NMI: nx.cpu.irqVector = `ISC_VEC_WDT;       // see R03
         ISC_OFF_BRK: nx.cpu.irqVector = `ISC_VEC_BREAK;     // see R05
         ISC_OFF_MASK: nx.cpu.irqVector = vecOf(selIdx);     // see R04
         default: nx.cpu.irqVector = st.cpu.irqVector;
      endcase

      // watchdog in restart mode reinitialises the controller, except in stop
      if (irqSrc.watchdogOverflowIrq && st.wdtMode == `ISC_WDT_RESTART
         && st.mode != ISC_STOP) begin
         nx = RST_STATE;                                     // see R05
         nx.pinMeta = {portFourPin, extEdgePin};
         nx.pinSync = st.pinMeta;
         nx.pinPrev = st.pinSync;
         nx.cpu.restartReq = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         st <= RST_STATE;
      end else begin
         st <= nx;
      end
   end
endmodule : isc_top

// *** verif/isc_asserts.sv ***
// port checker of the interrupt and standby control
`timescale 1ns/10ps
module isc_asserts import isc_pkg::*; (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire isc_apb_rsp_t apbRsp,
   input wire isc_cpu_req_t cpuReq,
   input wire isc_cpu_rsp_t cpuRsp
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   AST_ACK_DROP: assert property (cpuRsp.irqReq && cpuReq.irqAck |=> !cpuRsp.irqReq)
      else $error("offer stood after ack");
   AST_NMI_VEC: assert property (cpuRsp.irqReq && cpuRsp.irqNmi
      |-> cpuRsp.irqVector == 16'h4) else $error("bad nmi vector");
   AST_BRK_VEC: assert property (cpuRsp.irqReq && cpuRsp.irqBrk && !cpuRsp.irqNmi
      |-> cpuRsp.irqVector == 16'h3E) else $error("bad break vector");
   AST_MASK_VEC: assert property (cpuRsp.irqReq && !cpuRsp.irqNmi && !cpuRsp.irqBrk
      |-> cpuRsp.irqVector inside {16'h4, 16'h6, 16'h8, 16'hA, 16'hC, 16'hE, 16'h12, 16'h16,
      16'h18}) else $error("bad vector");
   AST_HALT_IN: assert property (cpuReq.instrValid && cpuReq.instrCode == ISC_I_HALT
      && cpuRsp.cpuClkRun |-> ##[1:2] !cpuRsp.cpuClkRun && cpuRsp.mainOscRun) else $error("halt");
   AST_STOP_IN: assert property (cpuReq.instrValid && cpuReq.instrCode == ISC_I_STOP
      && cpuRsp.cpuClkRun |-> ##[1:2] !cpuRsp.mainOscRun) else $error("stop");
   // cpu clock can never run off a stopped oscillator
   AST_OSC_CPU: assert property (!cpuRsp.mainOscRun |-> !cpuRsp.cpuClkRun)
      else $error("cpu runs in stop");
   AST_ERR_RDY: assert property (apbRsp.pslverr |-> apbRsp.pready)
      else $error("lone error");
endmodule : isc_asserts
bind isc_top isc_asserts chk (.sys_clk, .reset_n, .apbRsp, .cpuReq, .cpuRsp);

// *** verif/isc_cpu_model.sv ***
// core model that takes each offer after a chosen number of cycles
`timescale 1ns/10ps
module isc_cpu_model import isc_pkg::*; (
   input wire logic sys_clk,
   input wire isc_cpu_rsp_t cpuRsp,
   input wire logic [1:0] ackDelay,
   output logic irqAck,
   output logic took,
   output logic [15:0] takenVec
);
   logic [1:0] waitCnt = 2'h0;
   initial irqAck = 1'b0;
   // vector is taken at the edge where ack meets the offer, as it may change before
   always @(posedge sys_clk) begin
      took <= irqAck && cpuRsp.irqReq;
      if (irqAck && cpuRsp.irqReq) takenVec <= cpuRsp.irqVector;
      irqAck <= 1'b0;
      if (cpuRsp.irqReq && !irqAck) begin
         waitCnt <= (waitCnt == ackDelay) ? 2'h0 : waitCnt + 2'h1;
         irqAck <= (waitCnt == ackDelay);
      end
   end
endmodule : isc_cpu_model

// *** verif/interrupt_and_standby_control_bench.sv ***
// self-checking bench of the interrupt and standby control
`timescale 1ns/10ps
`define ISC_CMP(a, b) begin testsRun++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED at %0t: %h not %h", $time, a, b); end end
module interrupt_and_standby_control_bench import isc_pkg::*; ;
   logic sys_clk = 0, reset_n = 0, instrValid = 0, irqAck, took, err;
   isc_instr_t instrCode = ISC_I_OTHER;
   isc_apb_req_t apbReq = '0;
   isc_apb_rsp_t apbRsp;
   isc_cpu_rsp_t cpuRsp;
   isc_cpu_req_t cpuReq;
   isc_src_t irqSrc = '0;
   logic [3:0] extEdgePin = 4'hF;
   logic [1:0] ackDelay = 2'h0;
   logic [15:0] takenVec;
   logic [31:0] rd, v;
   int errors = 0, testsRun = 0, n;
   // expected vectors, in the order the tests raise them
   logic [15:0] vq[$] = '{16'h4, 16'hE, 16'h12, 16'h16, 16'h18, 16'hC, 16'h4, 16'h3E, 16'hE};
   assign cpuReq = '{instrValid, instrCode, irqAck};
   isc_top #(.SETTLE_CYC0(5)) uut (.sys_clk, .reset_n, .apbReq, .apbRsp, .cpuReq, .cpuRsp,
      .irqSrc, .stopCapable(5'h02), .extEdgePin, .portFourPin(8'hFF));
   isc_cpu_model core (.sys_clk, .cpuRsp, .ackDelay, .irqAck, .took, .takenVec);
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
   endtask : apb
   task automatic chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
      apb(1'b0, a, 32'h0);
      `ISC_CMP(rd & m, x)
   endtask : chk
   task automatic pulse(input logic [5:0] s);
      irqSrc <= s;
      @(posedge sys_clk);
      irqSrc <= '0;
   endtask : pulse
   task automatic instr(input isc_instr_t c);
      instrCode <= c;
      instrValid <= 1'b1;
      @(posedge sys_clk);
      instrValid <= 1'b0;
   endtask : instr
   task automatic tookChk;
      logic [15:0] e;
      e = vq.pop_front();
      do @(posedge sys_clk); while (took !== 1'b1);
      `ISC_CMP(takenVec, e)
   endtask : tookChk
   task automatic waitRun;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cpuRsp.cpuClkRun !== 1'b1);
   endtask : waitRun
   // stale flags are cleared first, else they would wake the block at once
   task automatic standby(input isc_instr_t c);
      apb(1'b1, 8'h0, 32'h0);
      instr(c);
      repeat (3) @(posedge sys_clk);
   endtask : standby
   task automatic printVerdict;
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : printVerdict
   initial forever #5 sys_clk = ~sys_clk;
   initial begin
      #100000;
      errors++;
      printVerdict;
   end
   initial begin
      void'($urandom(94177));
      v = $urandom & 32'h1FF;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(8'h4, 32'h3FF);
      chk(8'hC, 32'h2);
      chk(8'h28, 32'h0);
      `ISC_CMP(err, 1'b1)
      apb(1'b1, 8'h8, v);
      chk(8'h8, v);
      apb(1'b1, 8'h4, 32'h0);
      $display("test registers end");
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'h20, 32'h1);
         ackDelay <= i[1:0];
         if (i < 5) pulse(6'h20 >> i);
         else extEdgePin[3] <= 1'b0;
         tookChk;
      end
      chk(8'h20, {30'h0, ~v[4], 1'b0});
      chk(8'h0, 32'h0);
      $display("test vectors end");
      apb(1'b1, 8'h18, 32'h1);
      pulse(6'h30);
      tookChk;
      instr(ISC_I_BRK);
      tookChk;
      pulse(6'h01);
      chk(8'h0, 32'h220, 32'h3FE);
      apb(1'b1, 8'h20, 32'h1);
      tookChk;
      chk(8'h0, 32'h200, 32'h3FE);
      $display("test priority end");
      standby(ISC_I_HALT);
      `ISC_CMP({cpuRsp.cpuClkRun, cpuRsp.mainOscRun}, 2'b01)
      pulse(6'h04);
      waitRun;
      `ISC_CMP(n < 8, 1'b1)
      standby(ISC_I_STOP);
      pulse(6'h02);
      repeat (4) @(posedge sys_clk);
      `ISC_CMP({cpuRsp.cpuClkRun, cpuRsp.mainOscRun}, 2'b00)
      pulse(6'h10);
      waitRun;
      `ISC_CMP(n >= 5 && n < 12, 1'b1)
      $display("test standby end");
      printVerdict;
   end
endmodule : interrupt_and_standby_control_bench
